// File: core/stack_and_rotate_instr_exec.v
// Executor for user/system stack, return, carry clear and rotate instructions
`timescale 1ns/100ps
`include "stack_exec_defs.vh"

module stack_and_rotate_instr_exec (
  input wire clock,
  input wire rst_n,
  input wire start,
  input wire [7:0] opcode,
  input wire [7:0] operand_a,
  input wire [7:0] operand_b,
  output reg busy,
  output reg done,
  output reg illegal,
  output reg [1:0] instr_len,
  output reg [7:0] flags,
  output reg [15:0] stack_ptr,
  output reg [15:0] pc,
  output reg [7:0] rf_addr,
  output reg [7:0] rf_wdata,
  output reg rf_we,
  output reg rf_re,
  input wire [7:0] rf_rdata,
  output reg [15:0] mem_addr,
  output reg [7:0] mem_wdata,
  output reg mem_we,
  output reg mem_re,
  input wire [7:0] mem_rdata
);
  // ==================================================
  // States and instruction classes
  localparam [7:0] ST_IDLE = 8'h01;
  localparam [7:0] ST_RD1 = 8'h02;
  localparam [7:0] ST_RD2 = 8'h04;
  localparam [7:0] ST_RD3 = 8'h08;
  localparam [7:0] ST_WR = 8'h10;
  localparam [7:0] ST_WR2 = 8'h20;
  localparam [7:0] ST_WAIT = 8'h40;
  localparam [7:0] ST_DONE = 8'h80;

  localparam [7:0] CL_POP_INC = 8'h01;
  localparam [7:0] CL_PUSHS = 8'h02;
  localparam [7:0] CL_PUSH_DEC = 8'h04;
  localparam [7:0] CL_PUSH_INC = 8'h08;
  localparam [7:0] CL_CCF = 8'h10;
  localparam [7:0] CL_RET = 8'h20;
  localparam [7:0] CL_ROT = 8'h40;
  localparam [7:0] CL_BAD = 8'h80;

  reg [7:0] state;
  reg [7:0] iclass;
  reg indirect;
  reg [1:0] rot_kind;
  reg [7:0] ptr_addr;
  reg [7:0] ptr_val;
  reg [7:0] data_val;
  reg [7:0] dst_addr;
  reg [7:0] pc_high;
  reg [7:0] rot_in;
  reg [3:0] cycles;
  reg timer_load;
  wire timer_last;
  wire [7:0] rot_res;
  wire rot_c;
  wire rot_z;
  wire rot_s;
  wire rot_v;

  // ==================================================
  // Decode helpers
  function [7:0] class_of;
    input [7:0] op;
    begin
      if (op == `OPC_POP_USER_INC) class_of = CL_POP_INC;
      else if (op == `OPC_PUSH_SYS_R || op == `OPC_PUSH_SYS_IND) class_of = CL_PUSHS;
      else if (op == `OPC_PUSH_USER_DEC) class_of = CL_PUSH_DEC;
      else if (op == `OPC_PUSH_USER_INC) class_of = CL_PUSH_INC;
      else if (op == `OPC_CARRY_CLEAR) class_of = CL_CCF;
      else if (op == `OPC_RETURN) class_of = CL_RET;
      else if (op == `OPC_ROT_LEFT_R || op == `OPC_ROT_LEFT_IND || op == `OPC_ROT_LEFT_C_R ||
               op == `OPC_ROT_LEFT_C_IND || op == `OPC_ROT_RIGHT_R || op == `OPC_ROT_RIGHT_IND)
        class_of = CL_ROT;
      else class_of = CL_BAD;
    end
  endfunction

  function [3:0] cycles_of;
    input [7:0] cl;
    begin
      if (cl == CL_CCF) cycles_of = `CYC_CARRY_CLEAR;
      else if (cl == CL_ROT) cycles_of = `CYC_ROTATE;
      else if (cl == CL_RET) cycles_of = `CYC_RETURN;
      else if (cl == CL_PUSHS) cycles_of = `CYC_SYS_PUSH;
      else cycles_of = `CYC_USER_STACK;
    end
  endfunction

  function [1:0] len_of;
    input [7:0] cl;
    begin
      if (cl == CL_CCF || cl == CL_RET || cl == CL_BAD) len_of = `LEN_ONE_BYTE;
      else if (cl == CL_ROT) len_of = `LEN_ROTATE;
      else if (cl == CL_PUSHS) len_of = `LEN_SYS_PUSH;
      else len_of = `LEN_USER_STACK;
    end
  endfunction

  // ==================================================
  // Shared arithmetic and timing
  rotate_unit rotator (
    .kind(rot_kind),
    .operand(rot_in),
    .carry_in(flags[`FLAG_C]),
    .result(rot_res),
    .carry_out(rot_c),
    .zero_out(rot_z),
    .sign_out(rot_s),
    .overflow_out(rot_v)
  );

  cycle_timer timer (
    .clock(clock),
    .rst_n(rst_n),
    .load(timer_load),
    .count(cycles),
    .last(timer_last)
  );

  // ==================================================
  // Main sequencer. Register file and stack memory answer in the cycle
  // in which the read strobe stands; each instruction then idles in ST_WAIT
  // so the completion pulse lands on its documented cycle count.
  always @(posedge clock) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      iclass <= CL_BAD;
      indirect <= 1'b0;
      rot_kind <= 2'h0;
      ptr_addr <= 8'h00;
      ptr_val <= 8'h00;
      data_val <= 8'h00;
      dst_addr <= 8'h00;
      pc_high <= 8'h00;
      rot_in <= 8'h00;
      cycles <= 4'h0;
      timer_load <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      illegal <= 1'b0;
      instr_len <= 2'h0;
      flags <= `FLAGS_RESET;
      stack_ptr <= `SP_RESET;
      pc <= `PC_RESET;
      rf_addr <= 8'h00;
      rf_wdata <= 8'h00;
      rf_we <= 1'b0;
      rf_re <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 8'h00;
      mem_we <= 1'b0;
      mem_re <= 1'b0;
    end else begin
      rf_we <= 1'b0;
      rf_re <= 1'b0;
      mem_we <= 1'b0;
      mem_re <= 1'b0;
      done <= 1'b0;
      timer_load <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start) begin
            iclass <= class_of(opcode);
            cycles <= cycles_of(class_of(opcode)) - 4'h1; // Timer loads one cycle late
            instr_len <= len_of(class_of(opcode));
            timer_load <= 1'b1;
            busy <= 1'b1;
            illegal <= (class_of(opcode) == CL_BAD);
            indirect <= opcode[0];
            rot_kind <= (opcode[7:4] == 4'h9) ? 2'h0 : ((opcode[7:4] == 4'h1) ? 2'h1 : 2'h2);
            if (class_of(opcode) == CL_POP_INC) begin
              // Encoded source (pointer register) then destination
              ptr_addr <= operand_a;
              dst_addr <= operand_b;
              rf_addr <= operand_a;
              rf_re <= 1'b1;
              state <= ST_RD1;
            end else if (class_of(opcode) == CL_PUSH_DEC || class_of(opcode) == CL_PUSH_INC) begin
              // Encoded destination (pointer register) then source
              ptr_addr <= operand_a;
              rf_addr <= operand_b;
              rf_re <= 1'b1;
              state <= ST_RD1;
            end else if (class_of(opcode) == CL_PUSHS || class_of(opcode) == CL_ROT) begin
              rf_addr <= operand_a;
              rf_re <= 1'b1;
              state <= ST_RD1;
            end else if (class_of(opcode) == CL_RET) begin
              mem_addr <= stack_ptr;
              mem_re <= 1'b1;
              state <= ST_RD1;
            end else if (class_of(opcode) == CL_CCF) begin
              flags[`FLAG_C] <= 1'b0;
              state <= ST_WAIT;
            end else begin
              state <= ST_WAIT;
            end
          end
        end
        ST_RD1: begin
          if (iclass == CL_POP_INC) begin
            // Pointer value addresses the popped byte
            ptr_val <= rf_rdata;
            rf_addr <= rf_rdata;
            rf_re <= 1'b1;
            state <= ST_RD2;
          end else if (iclass == CL_PUSH_DEC || iclass == CL_PUSH_INC) begin
            data_val <= rf_rdata;
            rf_addr <= ptr_addr;
            rf_re <= 1'b1;
            state <= ST_RD2;
          end else if (iclass == CL_RET) begin
            pc_high <= mem_rdata;
            mem_addr <= stack_ptr + 16'h0001;
            mem_re <= 1'b1;
            state <= ST_RD2;
          end else if (indirect) begin
            // Named register holds the operand's address
            dst_addr <= rf_rdata;
            rf_addr <= rf_rdata;
            rf_re <= 1'b1;
            state <= ST_RD2;
          end else begin
            dst_addr <= rf_addr;
            rot_in <= rf_rdata;
            data_val <= rf_rdata;
            state <= ST_RD3;
          end
        end
        ST_RD2: begin
          if (iclass == CL_POP_INC) begin
            rf_addr <= dst_addr;
            rf_wdata <= rf_rdata;
            rf_we <= 1'b1;
            state <= ST_WR;
          end else if (iclass == CL_PUSH_DEC || iclass == CL_PUSH_INC) begin
            // Pointer moves first, then the source lands at the new spot
            ptr_val <= (iclass == CL_PUSH_DEC) ? rf_rdata - 8'h01 : rf_rdata + 8'h01;
            rf_addr <= ptr_addr;
            rf_wdata <= (iclass == CL_PUSH_DEC) ? rf_rdata - 8'h01 : rf_rdata + 8'h01;
            rf_we <= 1'b1;
            state <= ST_WR;
          end else if (iclass == CL_RET) begin
            pc <= {pc_high, mem_rdata};
            stack_ptr <= stack_ptr + 16'h0002;
            state <= ST_WAIT;
          end else begin
            rot_in <= rf_rdata;
            data_val <= rf_rdata;
            state <= ST_RD3;
          end
        end
        ST_RD3: begin
          if (iclass == CL_PUSHS) begin
            stack_ptr <= stack_ptr - 16'h0001;
            mem_addr <= stack_ptr - 16'h0001;
            mem_wdata <= data_val;
            mem_we <= 1'b1;
          end else begin
            rf_addr <= dst_addr;
            rf_wdata <= rot_res;
            rf_we <= 1'b1;
            flags[`FLAG_C] <= rot_c;
            flags[`FLAG_Z] <= rot_z;
            flags[`FLAG_S] <= rot_s;
            flags[`FLAG_V] <= rot_v;
          end
          state <= ST_WAIT;
        end
        ST_WR: begin
          if (iclass == CL_POP_INC) begin
            // Pop copies first, then the pointer steps up
            rf_addr <= ptr_addr;
            rf_wdata <= ptr_val + 8'h01;
            rf_we <= 1'b1;
          end else begin
            rf_addr <= ptr_val;
            rf_wdata <= data_val;
            rf_we <= 1'b1;
          end
          state <= ST_WR2;
        end
        ST_WR2: begin
          state <= ST_WAIT;
        end
        ST_WAIT: begin
          if (timer_last) begin
            done <= 1'b1;
            busy <= 1'b0;
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// File: core/stack_exec_defs.vh
// Opcodes, flag positions, cycle counts, instruction lengths and reset values for the stack/rotate executor
`ifndef STACK_EXEC_DEFS_VH
`define STACK_EXEC_DEFS_VH
// Opcodes
`define OPC_POP_USER_INC 8'h93
`define OPC_PUSH_SYS_R 8'h70
`define OPC_PUSH_SYS_IND 8'h71
`define OPC_PUSH_USER_DEC 8'h82
`define OPC_PUSH_USER_INC 8'h83
`define OPC_CARRY_CLEAR 8'hCF
`define OPC_RETURN 8'hAF
`define OPC_ROT_LEFT_R 8'h90
`define OPC_ROT_LEFT_IND 8'h91
`define OPC_ROT_LEFT_C_R 8'h10
`define OPC_ROT_LEFT_C_IND 8'h11
`define OPC_ROT_RIGHT_R 8'hE0
`define OPC_ROT_RIGHT_IND 8'hE1
// Flag bit positions in the flags byte
`define FLAG_C 7
`define FLAG_Z 6
`define FLAG_S 5
`define FLAG_V 4
`define FLAG_D 3
`define FLAG_H 2
// Cycle counts per instruction
`define CYC_USER_STACK 4'd8
`define CYC_SYS_PUSH 4'd8
`define CYC_CARRY_CLEAR 4'd4
`define CYC_RETURN 4'd10
`define CYC_ROTATE 4'd4
// Instruction lengths in bytes
`define LEN_USER_STACK 2'd3
`define LEN_SYS_PUSH 2'd2
`define LEN_ROTATE 2'd2
`define LEN_ONE_BYTE 2'd1
// Reset values
`define FLAGS_RESET 8'h00
`define SP_RESET 16'h0000
`define PC_RESET 16'h0000
`endif

// File: core/rotate_unit.v
// Combinational rotate unit with flag results
`timescale 1ns/100ps
module rotate_unit (
  input wire [1:0] kind,
  input wire [7:0] operand,
  input wire carry_in,
  output reg [7:0] result,
  output reg carry_out,
  output wire zero_out,
  output wire sign_out,
  output wire overflow_out
);
  // ==================================================
  // Rotation: 0 left, 1 left through carry, 2 right
  always @* begin
    case (kind)
      2'h0: begin
        result = {operand[6:0], operand[7]};
        carry_out = operand[7];
      end
      2'h1: begin
        result = {operand[6:0], carry_in};
        carry_out = operand[7];
      end
      default: begin
        result = {operand[0], operand[7:1]};
        carry_out = operand[0];
      end
    endcase
  end

  // Overflow is a sign change; zero and sign come from the result
  assign overflow_out = result[7] ^ operand[7];
  assign zero_out = (result == 8'h00);
  assign sign_out = result[7];
endmodule

// File: core/cycle_timer.v
// Down counter that holds an instruction for its documented cycle count
`timescale 1ns/100ps
module cycle_timer (
  input wire clock,
  input wire rst_n,
  input wire load,
  input wire [3:0] count,
  output wire last
);
  reg [3:0] remain;
  // ==================================================
  // Counts down to zero and holds; last marks the cycle at one, the final cycle
  always @(posedge clock) begin
    if (!rst_n) begin
      remain <= 4'h0;
    end else if (load) begin
      remain <= count;
    end else if (remain != 4'h0) begin
      remain <= remain - 4'h1;
    end
  end
  assign last = (remain == 4'h1);
endmodule

// File: sim/stack_partner.sv
// Behavioural register file and stack memory facing the executor
`timescale 1ns/100ps
// ====================
// Storage model
module stack_partner (
  input wire clock,
  input wire [7:0] rf_addr,
  input wire [7:0] rf_wdata,
  input wire rf_we,
  input wire rf_re,
  output logic [7:0] rf_rdata,
  input wire [15:0] mem_addr,
  input wire [7:0] mem_wdata,
  input wire mem_we,
  input wire mem_re,
  output logic [7:0] mem_rdata
);
  logic [7:0] rf [0:255];
  logic [7:0] mem [0:65535];
  // Data stands while the strobe stands; otherwise inverted so stray reads show
  assign rf_rdata = rf_re ? rf[rf_addr] : ~rf[rf_addr];
  assign mem_rdata = mem_re ? mem[mem_addr] : ~mem[mem_addr];
  // Writes land at the clock edge that sees the strobe
  always @(posedge clock) begin
    if (rf_we) rf[rf_addr] <= rf_wdata;
    if (mem_we) mem[mem_addr] <= mem_wdata;
  end
endmodule

// File: sim/stack_exec_asserts.sv
// Concurrent checks on the executor's ports
`timescale 1ns/100ps
// ====================
// Port checker
module stack_exec_asserts (
  input wire clock,
  input wire rst_n,
  input wire start,
  input wire [7:0] opcode,
  input wire busy,
  input wire done,
  input wire [7:0] flags,
  input wire [15:0] stack_ptr,
  input wire [15:0] pc,
  input wire [15:0] mem_addr,
  input wire mem_we,
  input wire mem_re
);
  logic [7:0] op;
  logic [7:0] f0;
  logic [15:0] sp0;
  // Taken only while idle; the done cycle itself refuses a request
  wire take = start && !busy && !done;
  wire rot_t = opcode inside {8'h90, 8'h91, 8'h10, 8'h11, 8'hE0, 8'hE1};
  wire stk_t = opcode inside {8'h93, 8'h82, 8'h83, 8'h70, 8'h71};
  wire rot_d = op inside {8'h90, 8'h91, 8'h10, 8'h11, 8'hE0, 8'hE1};
  wire push_d = op inside {8'h70, 8'h71};
  wire calm_d = op inside {8'h93, 8'h82, 8'h83, 8'h70, 8'h71, 8'hAF};
  // Context latched when a request is taken
  always @(posedge clock) begin
    if (take) begin
      op <= opcode;
      f0 <= flags;
      sp0 <= stack_ptr;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  AST_ROT_TIME: assert property (take && (rot_t || opcode == 8'hCF) |=> busy [*3] ##[1:2] done)
    else $error("short op late");
  AST_STACK_TIME: assert property (take && stk_t |=> busy [*7] ##[1:2] done)
    else $error("stack op late");
  AST_RET_TIME: assert property (take && opcode == 8'hAF |=> busy [*8] ##[1:3] done)
    else $error("return late");
  AST_CARRY_CLEAR: assert property (done && op == 8'hCF |-> flags == {1'b0, f0[6:0]})
    else $error("carry clear flags wrong");
  AST_FLAGS_KEPT: assert property (done && calm_d |-> flags == f0)
    else $error("flags changed");
  AST_ROT_DH: assert property (done && rot_d |-> flags[3:2] == f0[3:2])
    else $error("decimal or half flag changed");
  AST_RET_SP: assert property (done && op == 8'hAF |-> stack_ptr == sp0 + 16'h0002)
    else $error("return pointer wrong");
  AST_PUSH_SP: assert property (done && push_d |-> stack_ptr == sp0 - 16'h0001)
    else $error("push pointer wrong");
  AST_PUSH_ADDR: assert property (mem_we |-> push_d && mem_addr == sp0 - 16'h0001)
    else $error("push address wrong");
  AST_RET_ADDR: assert property (mem_re |-> op == 8'hAF && (mem_addr == sp0 || mem_addr == sp0 + 16'h0001))
    else $error("return read address wrong");
  AST_PC_RET: assert property ($changed(pc) |-> op == 8'hAF)
    else $error("pc moved outside return");
endmodule
bind stack_and_rotate_instr_exec stack_exec_asserts i_chk (.clock, .rst_n, .start, .opcode, .busy, .done, .flags,
  .stack_ptr, .pc, .mem_addr, .mem_we, .mem_re);

// File: sim/testbench.sv
// Self-checking bench for the stack and rotate executor
`timescale 1ns/100ps
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin n_errors++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, s); end end
// ====================
// Bench top
module testbench;
  typedef struct {
    logic [7:0] f;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [1:0] len;
    logic [7:0] ra;
    logic [7:0] rv;
    logic [7:0] rb;
    logic [7:0] rbv;
    logic [15:0] ma;
    logic [7:0] mv;
    logic il;
  } note_t;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic [7:0] opcode = 8'h00;
  logic [7:0] operand_a = 8'h00;
  logic [7:0] operand_b = 8'h00;
  wire busy, done, illegal, rf_we, rf_re, mem_we, mem_re;
  wire [1:0] instr_len;
  wire [7:0] flags, rf_addr, rf_wdata, rf_rdata, mem_wdata, mem_rdata;
  wire [15:0] stack_ptr, pc, mem_addr;
  note_t q[$];
  note_t m;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [7:0] ef = 8'h00;
  logic [15:0] esp = 16'h0000;
  logic [15:0] epc = 16'h0000;
  logic [7:0] ops [0:12] = '{8'h93, 8'h70, 8'h71, 8'h82, 8'h83, 8'hAF, 8'hCF, 8'h90, 8'h91, 8'h10, 8'h11, 8'hE0, 8'hE1};
  stack_and_rotate_instr_exec i_stack_and_rotate_instr_exec (.clock, .rst_n, .start, .opcode, .operand_a, .operand_b,
    .busy, .done, .illegal, .instr_len, .flags, .stack_ptr, .pc, .rf_addr, .rf_wdata, .rf_we, .rf_re, .rf_rdata,
    .mem_addr, .mem_wdata, .mem_we, .mem_re, .mem_rdata);
  stack_partner i_stack_partner (.clock, .rf_addr, .rf_wdata, .rf_we, .rf_re, .rf_rdata, .mem_addr, .mem_wdata,
    .mem_we, .mem_re, .mem_rdata);
  initial forever #5 clock = ~clock;
  task automatic close_out;
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Cycle ceiling so a hung handshake still ends the run
  always @(posedge clock) begin
    cyc++;
    if (cyc == 6000) begin
      n_errors++;
      close_out;
    end
  end
  // Each done pulse retires the oldest note
  always @(posedge clock) begin
    if (done === 1'b1) begin
      if (q.size() == 0) `CHK("note", 1'b1, 1'b0)
      else begin
        m = q.pop_front();
        `CHK("flags", m.f, flags)
        `CHK("sp", m.sp, stack_ptr)
        `CHK("pc", m.pc, pc)
        `CHK("len", m.len, instr_len)
        `CHK("reg a", m.rv, i_stack_partner.rf[m.ra])
        `CHK("reg b", m.rbv, i_stack_partner.rf[m.rb])
        `CHK("stack", m.mv, i_stack_partner.mem[m.ma])
        `CHK("illegal", m.il, illegal)
      end
    end
  end
  // Work out the expected outcome from the storage, then issue one request
  task automatic run(input logic [7:0] op, input logic [7:0] a, input logic [7:0] b);
    note_t n;
    logic [7:0] p;
    logic [7:0] x;
    logic [7:0] r;
    logic c;
    p = i_stack_partner.rf[a];
    x = op[0] ? i_stack_partner.rf[p] : p;
    n.ra = a;
    n.rv = p;
    n.rb = a;
    n.rbv = p;
    n.il = !(op inside {8'h93, 8'h70, 8'h71, 8'h82, 8'h83, 8'hAF, 8'hCF, 8'h90, 8'h91, 8'h10, 8'h11, 8'hE0,
      8'hE1});
    n.len = (op inside {8'h93, 8'h82, 8'h83}) ? 2'h3 : (n.il || op inside {8'hAF, 8'hCF}) ? 2'h1 : 2'h2;
    if (op == 8'h93) begin
      n.rb = b;
      n.rbv = i_stack_partner.rf[p];
      n.rv = p + 8'h01;
    end else if (op == 8'h82 || op == 8'h83) begin
      p = op[0] ? p + 8'h01 : p - 8'h01;
      n.rb = p;
      n.rbv = i_stack_partner.rf[b];
      n.rv = (p == a) ? n.rbv : p;
    end else if (op == 8'h70 || op == 8'h71) begin
      esp = esp - 16'h0001;
    end else if (op == 8'hAF) begin
      epc = {i_stack_partner.mem[esp], i_stack_partner.mem[esp + 16'h0001]};
      esp = esp + 16'h0002;
    end else if (op == 8'hCF) begin
      ef[7] = 1'b0;
    end else if (!n.il) begin
      case (op[7:4])
        4'h9: {r, c} = {x[6:0], x[7], x[7]};
        4'h1: {r, c} = {x[6:0], ef[7], x[7]};
        default: {r, c} = {x[0], x[7:1], x[0]};
      endcase
      ef[7:4] = {c, r == 8'h00, r[7], r[7] ^ x[7]};
      n.ra = op[0] ? p : a;
      n.rv = r;
      n.rb = n.ra;
      n.rbv = r;
    end
    n.ma = esp;
    n.mv = (op == 8'h70 || op == 8'h71) ? x : i_stack_partner.mem[esp];
    n.f = ef;
    n.sp = esp;
    n.pc = epc;
    q.push_back(n);
    @(posedge clock);
    start <= 1'b1;
    opcode <= op;
    operand_a <= a;
    operand_b <= b;
    @(posedge clock);
    start <= 1'b0;
    repeat (14) begin
      @(posedge clock);
      if (done === 1'b1) break;
    end
    repeat (2) @(posedge clock);
  endtask
  // Main sequence: reset, directed corner values, then every opcode with random operands
  initial begin
    logic [7:0] a;
    logic [7:0] b;
    void'($urandom(39821));
    for (int k = 0; k < 65536; k++) begin
      i_stack_partner.mem[k] = $urandom;
      if (k < 256) i_stack_partner.rf[k] = $urandom;
    end
    repeat (6) @(posedge clock);
    `CHK("reset sp", 16'h0000, stack_ptr)
    rst_n <= 1'b1;
    i_stack_partner.rf[8'h20] = 8'h00;
    run(8'h90, 8'h20, 8'h00);
    i_stack_partner.rf[8'h21] = 8'h80;
    run(8'hE1, 8'h22, 8'h00);
    run(8'h10, 8'h21, 8'h00);
    run(8'h5A, 8'h30, 8'h31); // Unknown opcode: flagged, no effect
    for (int k = 0; k < 65; k++) begin
      a = $urandom;
      b = $urandom;
      if (b == a) b = ~a;
      run(ops[k % 13], a, b);
    end
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    `CHK("reset pc", 16'h0000, pc)
    // Second release: model back to reset values, then one request at once
    rst_n <= 1'b1;
    ef = 8'h00;
    esp = 16'h0000;
    epc = 16'h0000;
    run(8'hCF, 8'h40, 8'h41);
    `CHK("notes left", 0, q.size())
    close_out;
  end
endmodule
